// ---- rtl/hall_switch_defs.svh ----
// register indices, field layout and fixed constants of the field switch
`ifndef HALL_SWITCH_DEFS_SVH
`define HALL_SWITCH_DEFS_SVH
`define RI_MODE 4'h0
`define RI_TC 4'h1
`define RI_QUADRATIC_TEMP_COEFF 4'h2
`define RI_GAIN 4'h3
`define RI_OFFSET 4'h4
`define RI_LOW 4'h5
`define RI_HIGH 4'h6
`define RI_LOCK 4'h7
`define RI_SAMPLE 4'h8
`define RI_TRIM0 4'h9
`define RI_LAST 4'hb
`define NUM_REGS 12
`define MASK_MODE 16'h003f
`define MASK_COEFF 16'h00ff
`define MASK_GAIN 16'h3fff
`define MASK_OFFSET 16'h07ff
`define MASK_LOW 16'h07ff
`define MASK_HIGH 16'h0fff
`define MASK_LOCK 16'h0001
`define MASK_TRIM 16'hffff
`define REG_RESET 16'h0000
`define MODE_RANGE_LSB 0
`define MODE_FILTER_LSB 3
`define GAIN_FRAC 11
`define SPAN 16'h0800
`define TC_SQ_SHIFT 4
`define TC_FRAC 14
`define FLT_ACC_SHIFT 8
`define FLT_K0 3'h7
`define FLT_K1 3'h6
`define FLT_K2 3'h4
`define FLT_K3 3'h3
`define FLT_K4 3'h2
`define FLT_MIN0 14'h3080
`define FLT_MAX0 14'h0f7f
`define FLT_MIN1 14'h383f
`define FLT_MAX1 14'h07c1
`define FLT_MIN2 14'h2b54
`define FLT_MAX2 14'h14aa
`define FLT_MIN3 14'h35aa
`define FLT_MAX3 14'h0a55
`define FLT_MIN4 14'h3a18
`define FLT_MAX4 14'h05e7
`endif

// ---- rtl/hall_switch_pkg.sv ----
// shared types of the field switch
package hall_switch_pkg;
  typedef logic [15:0] word_t;
  typedef logic signed [15:0] sig_t;
  typedef logic signed [13:0] sample_t;
  typedef enum logic [0:0] {
    ST_LOAD = 1'b0,
    ST_RUN = 1'b1
  } ld_state_e;
endpackage

// ---- rtl/signal_path_if.sv ----
// configuration and signal bundle between the control, scaler and comparator
`timescale 1ns/1ps
interface signal_path_if;
  import hall_switch_pkg::*;
  sample_t sample;
  logic sample_valid;
  logic signed [13:0] gain;
  logic signed [10:0] offset;
  logic signed [7:0] tc;
  logic signed [7:0] quadratic_temp_coeff;
  logic signed [7:0] temp;
  logic [10:0] low;
  logic [11:0] high;
  logic run;
  sig_t sig;
  logic sig_valid;
  logic sw;
  modport ctl (output sample, sample_valid, gain, offset, tc, quadratic_temp_coeff, temp, low, high, run,
    input sig, sig_valid, sw);
  modport dsp (input sample, sample_valid, gain, offset, tc, quadratic_temp_coeff, temp, output sig, sig_valid);
  modport cmp (input sig, sig_valid, low, high, run, output sw);
endinterface

// ---- rtl/signal_scaler.sv ----
// gain with temperature correction, offset add and output limiting
`timescale 1ns/1ps
`include "hall_switch_defs.svh"
module signal_scaler
  import hall_switch_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  signal_path_if.dsp c
);
  logic signed [23:0] dt;
  logic signed [23:0] dt2;
  logic signed [23:0] corr;
  logic signed [39:0] gcorr;
  sig_t geff;
  logic signed [31:0] scaled;
  logic signed [31:0] sum;
  sig_t off2;
  sig_t hi;
  sig_t sig_d;
  sig_t sig_q;
  logic valid_q;

  // ************
  // temperature corrected gain
  // ************
  assign dt = 24'(c.temp);
  assign dt2 = dt * dt;
  assign corr = 24'(c.tc) * dt + ((24'(c.quadratic_temp_coeff) * dt2) >>> `TC_SQ_SHIFT); // RULE17
  assign gcorr = 40'(c.gain) * 40'(corr);
  assign geff = 16'(40'(c.gain) + (gcorr >>> `TC_FRAC)); // RULE17

  // ************
  // scale, shift, limit
  // ************
  // unity gain is 2048, so 2048 sample counts move the signal one span
  assign scaled = (32'(geff) * 32'(c.sample)) >>> `GAIN_FRAC; // RULE2 RULE3
  assign off2 = 16'(c.offset) <<< 1;
  assign sum = scaled + 32'(off2); // RULE4
  // a negative offset pulls the ceiling down with it
  assign hi = c.offset < 0 ? off2 + $signed(`SPAN) : $signed(`SPAN); // RULE5
  assign sig_d = sum < 0 ? '0 : (sum > 32'(hi) ? hi : 16'(sum));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sig_q <= '0;
      valid_q <= 1'b0;
    end else begin
      valid_q <= c.sample_valid;
      if (c.sample_valid) begin
        sig_q <= sig_d;
      end
    end
  end

  assign c.sig = sig_q;
  assign c.sig_valid = valid_q;

  a_sig_limit: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
    c.sample_valid && c.offset < 0 |=> sig_q <= $past(off2) + $signed(`SPAN))
    else $error("signal above offset plus span");
endmodule

// ---- rtl/switch_comparator.sv ----
// hysteresis comparator driving the switch state
`timescale 1ns/1ps
module switch_comparator
  import hall_switch_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  signal_path_if.cmp c
);
  logic above;
  logic below;
  logic sw_q;

  assign above = c.sig > $signed(16'(c.high));
  assign below = c.sig < $signed(16'(c.low));

  // high means off; held off until the configuration is loaded
  always_ff @(posedge clk_i) begin
    if (rst_i || !c.run) begin
      sw_q <= 1'b1; // RULE20
    end else if (c.sig_valid && above) begin
      sw_q <= 1'b0; // RULE1
    end else if (c.sig_valid && below) begin
      sw_q <= 1'b1; // RULE1
    end else begin
      sw_q <= sw_q; // RULE19
    end
  end

  assign c.sw = sw_q;

  a_sw_operate: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
    c.run && c.sig_valid && above ##1 c.run |-> !sw_q)
    else $error("switch not on above operate level");
  a_sw_release: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
    c.run && c.sig_valid && below && !above ##1 c.run |-> sw_q)
    else $error("switch not off below release level");
  a_sw_hold: assert property (@(posedge clk_i) disable iff (rst_i) // RULE19
    c.run && (!c.sig_valid || (!above && !below)) ##1 c.run |-> $stable(sw_q))
    else $error("switch moved inside hysteresis band");
endmodule

// ---- rtl/hall_switch_dsp_config.sv ----
// field switch signal path with nonvolatile configuration store
// Operation
// RULE1: switch low above operate, high below release
// RULE2: multiply filtered sample by gain first
// RULE3: gain step 1/2048, unity gives one span
// RULE4: add signed offset to scaled sample
// RULE5: negative offset lowers the signal ceiling
// RULE6: release to half span, operate to span; code lets release reach 2047 and operate 4095
// RULE7: mode low bits choose field range
// RULE8: mode high bits choose filter corner
// RULE9: filtered sample clamped per filter bound
// RULE10: sample polarity kept, low-pass before readout
// RULE11: readable 14-bit filtered sample register
// RULE12: set lock freezes everything after power cycle
// RULE13: lock cannot be cleared, programming off
// RULE14: commands answered, switch output suspended meanwhile
// RULE15: programmer talks only while unlocked
// RULE16: factory trim registers are read only
// RULE17: temperature coefficients correct the gain
// RULE18: programmer keeps sample inside bounds
// RULE19: between thresholds the switch holds state
// RULE20: load configuration before switching output
`timescale 1ns/1ps
`include "hall_switch_defs.svh"
module hall_switch_dsp_config
  import hall_switch_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [13:0] adc_i,
  input wire logic adc_valid_i,
  input wire logic [7:0] temp_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic [3:0] cmd_addr_i,
  input wire logic [15:0] cmd_wdata_i,
  input wire logic comm_active_i,
  input wire logic reply_bit_i,
  input wire logic [15:0] nvm_rdata_i,
  output logic [3:0] nvm_addr_o,
  output logic [15:0] nvm_wdata_o,
  output logic nvm_we_o,
  output logic [15:0] rdata_o,
  output logic rvalid_o,
  output logic [2:0] range_sel_o,
  output logic cfg_ready_o,
  output logic locked_o,
  output logic out_o
);
  signal_path_if sp ();

  // ************
  // configuration store
  // ************
  ld_state_e state_q;
  logic [3:0] idx_q;
  word_t reg_q [`NUM_REGS];
  logic [`NUM_REGS-1:0] ld_hit;
  logic [`NUM_REGS-1:0] wr_hit;
  logic lock_act_q;
  logic acc;
  logic acc_wr;
  logic wr_ok;
  logic lock_wr;
  logic nvm_req;
  word_t wr_val;
  word_t rd_val;
  logic rd_range;
  logic [3:0] waddr_q;
  word_t wdata_q;
  logic we_q;
  word_t rdata_q;
  logic rvalid_q;

  function automatic word_t reg_mask(input logic [3:0] a);
    case (a)
      `RI_MODE: reg_mask = `MASK_MODE;
      `RI_TC: reg_mask = `MASK_COEFF;
      `RI_QUADRATIC_TEMP_COEFF: reg_mask = `MASK_COEFF;
      `RI_GAIN: reg_mask = `MASK_GAIN;
      `RI_OFFSET: reg_mask = `MASK_OFFSET;
      `RI_LOW: reg_mask = `MASK_LOW;
      `RI_HIGH: reg_mask = `MASK_HIGH;
      `RI_LOCK: reg_mask = `MASK_LOCK;
      `RI_SAMPLE: reg_mask = `REG_RESET;
      default: reg_mask = `MASK_TRIM;
    endcase
  endfunction

  // once locked, commands get neither an answer nor a memory access
  assign acc = cmd_valid_i && state_q == ST_RUN && !lock_act_q; // RULE12 RULE15
  assign acc_wr = acc && cmd_write_i;
  // trim words sit above the lock index and never take a write
  assign wr_ok = cmd_addr_i <= `RI_LOCK; // RULE16
  assign lock_wr = cmd_addr_i == `RI_LOCK;
  // lock only ever gains ones: no write path can clear it
  assign wr_val = lock_wr ? (reg_q[`RI_LOCK] | cmd_wdata_i) : cmd_wdata_i; // RULE13
  assign nvm_req = acc_wr && wr_ok && !(lock_wr && !cmd_wdata_i[0]);
  // indices past the last word read as zero rather than unknown
  assign rd_range = cmd_addr_i <= `RI_LAST;
  assign rd_val = !rd_range ? '0 :
                  cmd_addr_i == `RI_SAMPLE ? 16'(sp.sample) : reg_q[cmd_addr_i]; // RULE11

  for (genvar i = 0; i < `NUM_REGS; i++) begin : g_reg
    assign ld_hit[i] = state_q == ST_LOAD && idx_q == 4'(i);
    assign wr_hit[i] = acc_wr && wr_ok && cmd_addr_i == 4'(i);
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        reg_q[i] <= `REG_RESET;
      end else if (ld_hit[i]) begin
        reg_q[i] <= nvm_rdata_i & reg_mask(4'(i)); // RULE20
      end else if (wr_hit[i]) begin
        reg_q[i] <= wr_val & reg_mask(4'(i));
      end
    end
  end

  // ************
  // power-up load sequence
  // ************
  // reset stands for a power cycle: the stored lock takes hold only here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_LOAD;
      idx_q <= 4'h0;
      lock_act_q <= 1'b0;
    end else begin
      case (state_q)
        ST_LOAD: begin
          idx_q <= idx_q + 4'h1;
          if (idx_q == `RI_LOCK) begin
            lock_act_q <= nvm_rdata_i[0]; // RULE12
          end
          if (idx_q == `RI_LAST) begin
            state_q <= ST_RUN; // RULE20
          end
        end
        ST_RUN: begin
          state_q <= ST_RUN;
        end
        default: begin
          state_q <= ST_LOAD;
        end
      endcase
    end
  end

  // ************
  // command answers and memory writes
  // ************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      we_q <= 1'b0;
      waddr_q <= 4'h0;
      wdata_q <= '0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      we_q <= nvm_req; // RULE14
      rvalid_q <= acc; // RULE14
      if (nvm_req) begin
        waddr_q <= cmd_addr_i;
        wdata_q <= wr_val & reg_mask(cmd_addr_i);
      end
      if (acc) begin
        rdata_q <= rd_val;
      end
    end
  end

  assign nvm_addr_o = state_q == ST_LOAD ? idx_q : waddr_q;
  assign nvm_wdata_o = wdata_q;
  assign nvm_we_o = we_q;
  assign rdata_o = rdata_q;
  assign rvalid_o = rvalid_q;
  assign cfg_ready_o = state_q == ST_RUN;
  assign locked_o = lock_act_q;

  // ************
  // low-pass filter
  // ************
  logic [2:0] flt_sel;
  logic [2:0] flt_k;
  sample_t fmin;
  sample_t fmax;
  logic signed [23:0] acc_q;
  logic signed [23:0] step;
  logic signed [23:0] fraw;
  sample_t filt_d;
  sample_t filt_q;
  logic fvalid_q;

  assign flt_sel = reg_q[`RI_MODE][`MODE_FILTER_LSB +: 3]; // RULE8
  assign range_sel_o = reg_q[`RI_MODE][`MODE_RANGE_LSB +: 3]; // RULE7

  // unused filter codes fall back to the widest corner
  assign flt_k = flt_sel == 3'h0 ? `FLT_K0 :
                 flt_sel == 3'h1 ? `FLT_K1 :
                 flt_sel == 3'h2 ? `FLT_K2 :
                 flt_sel == 3'h3 ? `FLT_K3 : `FLT_K4; // RULE8
  assign fmin = flt_sel == 3'h0 ? `FLT_MIN0 :
                flt_sel == 3'h1 ? `FLT_MIN1 :
                flt_sel == 3'h2 ? `FLT_MIN2 :
                flt_sel == 3'h3 ? `FLT_MIN3 : `FLT_MIN4;
  assign fmax = flt_sel == 3'h0 ? `FLT_MAX0 :
                flt_sel == 3'h1 ? `FLT_MAX1 :
                flt_sel == 3'h2 ? `FLT_MAX2 :
                flt_sel == 3'h3 ? `FLT_MAX3 : `FLT_MAX4;

  // first order section; sign of the sample is kept, north stays positive
  assign step = ((24'($signed(adc_i)) <<< `FLT_ACC_SHIFT) - acc_q) >>> flt_k; // RULE10
  assign fraw = (acc_q + step) >>> `FLT_ACC_SHIFT;
  assign filt_d = fraw < 24'(fmin) ? fmin :
                  (fraw > 24'(fmax) ? fmax : 14'(fraw)); // RULE9

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_q <= '0;
      filt_q <= '0;
      fvalid_q <= 1'b0;
    end else begin
      fvalid_q <= adc_valid_i;
      if (adc_valid_i) begin
        acc_q <= acc_q + step;
        filt_q <= filt_d; // RULE10
      end
    end
  end

  // ************
  // signal path
  // ************
  assign sp.sample = filt_q;
  assign sp.sample_valid = fvalid_q && state_q == ST_RUN;
  assign sp.gain = reg_q[`RI_GAIN][13:0]; // RULE3
  assign sp.offset = reg_q[`RI_OFFSET][10:0]; // RULE4
  assign sp.tc = reg_q[`RI_TC][7:0]; // RULE17
  assign sp.quadratic_temp_coeff = reg_q[`RI_QUADRATIC_TEMP_COEFF][7:0]; // RULE17
  assign sp.temp = temp_i;
  // release tops out just under one span, operate just under two spans
  assign sp.low = reg_q[`RI_LOW][10:0]; // RULE6
  assign sp.high = reg_q[`RI_HIGH][11:0]; // RULE6
  assign sp.run = state_q == ST_RUN;

  signal_scaler u_scaler (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .c(sp.dsp)
  );

  switch_comparator u_cmp (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .c(sp.cmp)
  );

  // ************
  // output pin
  // ************
  logic out_q;

  // the link owns the pin while talking; a locked part never talks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_q <= 1'b1;
    end else if (comm_active_i && !lock_act_q) begin
      out_q <= reply_bit_i; // RULE14
    end else begin
      out_q <= sp.sw;
    end
  end

  assign out_o = out_q;

  // ************
  // checks
  // ************
  a_lock_no_answer: assert property (@(posedge clk_i) disable iff (rst_i) // RULE12
    lock_act_q && cmd_valid_i |=> !rvalid_q && !we_q)
    else $error("locked part answered a command");
  a_lock_sticky: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
    state_q == ST_RUN && reg_q[`RI_LOCK][0] |=> reg_q[`RI_LOCK][0])
    else $error("lock bit cleared");
  a_lock_nvm: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
    we_q && waddr_q == `RI_LOCK |-> wdata_q[0])
    else $error("memory write clears lock");
  a_trim_ro: assert property (@(posedge clk_i) disable iff (rst_i) // RULE16
    we_q |-> waddr_q <= `RI_LOCK)
    else $error("trim word written");
  a_sample_bound: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9
    adc_valid_i |=> filt_q >= $past(fmin) && filt_q <= $past(fmax))
    else $error("filtered sample out of bound");
  a_comm_reply: assert property (@(posedge clk_i) disable iff (rst_i) // RULE14
    comm_active_i && !lock_act_q |=> out_o == $past(reply_bit_i))
    else $error("pin not handed to reply");
  a_load_first: assert property (@(posedge clk_i) disable iff (rst_i) // RULE20
    state_q == ST_LOAD ##1 state_q == ST_LOAD && !comm_active_i |=> out_o)
    else $error("output switched before load");
  a_read_answer: assert property (@(posedge clk_i) disable iff (rst_i) // RULE14
    acc && !cmd_write_i |=> rvalid_o && rdata_o == $past(rd_val))
    else $error("read not answered");
  a_write_strobe: assert property (@(posedge clk_i) disable iff (rst_i) // RULE14
    acc && cmd_write_i && cmd_addr_i < `RI_LOCK |=> nvm_we_o && nvm_addr_o == $past(cmd_addr_i))
    else $error("accepted write not stored");
  a_read_no_write: assert property (@(posedge clk_i) disable iff (rst_i) // RULE14
    acc && !cmd_write_i |=> !nvm_we_o)
    else $error("read caused a memory write");
  a_lock_write_zero: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
    acc && cmd_write_i && cmd_addr_i == `RI_LOCK && !cmd_wdata_i[0] |=> !nvm_we_o)
    else $error("lock write of zero reached memory");
  a_lock_frozen: assert property (@(posedge clk_i) disable iff (rst_i) // RULE12
    lock_act_q |=> $stable({reg_q[`RI_MODE], reg_q[`RI_TC], reg_q[`RI_QUADRATIC_TEMP_COEFF], reg_q[`RI_GAIN],
      reg_q[`RI_OFFSET], reg_q[`RI_LOW], reg_q[`RI_HIGH], reg_q[`RI_LOCK]}))
    else $error("register changed while locked");
  a_lock_no_prog: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
    lock_act_q |-> !nvm_we_o)
    else $error("memory written while locked");
  a_lock_reads: assert property (@(posedge clk_i) disable iff (rst_i) // RULE12
    lock_act_q && cmd_valid_i |=> $stable(rdata_o))
    else $error("locked part changed its answer");

  // ************
  // checks: power-up, trim, pin and sample read
  // ************
  a_load_ends: assert property (@(posedge clk_i) disable iff (rst_i) // RULE20
    state_q == ST_LOAD |-> ##[1:12] state_q == ST_RUN)
    else $error("load sequence too long");
  a_load_ignored: assert property (@(posedge clk_i) disable iff (rst_i) // RULE20
    state_q == ST_LOAD && cmd_valid_i |=> !rvalid_o && !nvm_we_o)
    else $error("command taken during load");
  a_trim_answer: assert property (@(posedge clk_i) disable iff (rst_i) // RULE16
    acc && cmd_write_i && cmd_addr_i > `RI_LOCK |=> rvalid_o && !nvm_we_o)
    else $error("read-only write reached memory");
  a_trim_kept: assert property (@(posedge clk_i) disable iff (rst_i) // RULE16
    state_q == ST_RUN |=> $stable(reg_q[`RI_TRIM0]))
    else $error("trim word changed");
  a_pin_switch: assert property (@(posedge clk_i) disable iff (rst_i) // RULE14
    !comm_active_i || lock_act_q |=> out_o == $past(sp.sw))
    else $error("pin left the switch state");
  a_sample_read: assert property (@(posedge clk_i) disable iff (rst_i) // RULE11
    acc && !cmd_write_i && cmd_addr_i == `RI_SAMPLE |=> rdata_o == 16'($past(filt_q)))
    else $error("sample read wrong");
endmodule

// ---- bench/supply_programmer.sv ----
// programmer model: command strobes over the supply link and answer phases
`timescale 1ns/1ps
module supply_programmer (
  input wire logic clk_i,
  input wire logic locked_i,
  input wire logic rvalid_i,
  input wire logic [15:0] rdata_i,
  output logic cmd_valid_o,
  output logic cmd_write_o,
  output logic [3:0] cmd_addr_o,
  output logic [15:0] cmd_wdata_o,
  output logic comm_active_o,
  output logic reply_bit_o
);
  // ****************************************
  // command and answer phases
  // ****************************************
  initial begin
    cmd_valid_o = 1'b0;
    cmd_write_o = 1'b0;
    cmd_addr_o = 4'h0;
    cmd_wdata_o = 16'h0000;
    comm_active_o = 1'b0;
    reply_bit_o = 1'b0;
  end

  task automatic xfer(input logic wr, input logic [3:0] a, input logic [15:0] d,
      output logic ok, output logic [15:0] q);
    ok = 1'b0;
    q = 16'h0000;
    @(posedge clk_i);
    comm_active_o <= ~locked_i;
    cmd_valid_o <= 1'b1;
    cmd_write_o <= wr;
    cmd_addr_o <= a;
    cmd_wdata_o <= d;
    @(posedge clk_i);
    cmd_valid_o <= 1'b0;
    // released lines show no stale value
    cmd_addr_o <= ~a;
    cmd_wdata_o <= ~d;
    repeat (2) begin
      @(negedge clk_i);
      if (rvalid_i === 1'b1 && !ok) begin
        ok = 1'b1;
        q = rdata_i;
      end
    end
    @(posedge clk_i);
    comm_active_o <= 1'b0;
  endtask

  task automatic talk(input logic b);
    @(posedge clk_i);
    comm_active_o <= ~locked_i;
    reply_bit_o <= b;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic quiet;
    @(posedge clk_i);
    comm_active_o <= 1'b0;
    reply_bit_o <= ~reply_bit_o;
  endtask
endmodule

// ---- bench/hall_switch_dsp_config_tb_top.sv ----
// self-checking bench of the field switch signal path and config store
`timescale 1ns/1ps
module hall_switch_dsp_config_tb_top;
  import hall_switch_pkg::*;
  // ****************************************
  // stimulus, storage model and device
  // ****************************************
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [13:0] adc_i = 14'h0000;
  logic adc_valid_i = 1'b1;
  logic [7:0] temp_i = 8'h00;
  logic [15:0] nvm [16];
  logic cmd_valid, cmd_write, comm_active, reply_bit, nvm_we, rvalid, cfg_ready, locked, out;
  logic [3:0] cmd_addr, nvm_addr;
  logic [15:0] cmd_wdata, nvm_wdata, rdata;
  logic [2:0] range_sel;
  int error_cnt = 0;
  int n_tests = 0;

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  initial begin
    for (int i = 0; i < 16; i++) nvm[i] = 16'h0000;
    nvm[0] = 16'h0023;
    nvm[3] = 16'h0800;
    nvm[5] = 16'h0190;
    nvm[6] = 16'h03e8;
    nvm[9] = 16'hbeef;
  end

  always @(posedge clk_i) begin
    if (nvm_we === 1'b1) nvm[nvm_addr] <= nvm_wdata;
  end

  hall_switch_dsp_config u_dut (.clk_i(clk_i), .rst_i(rst_i), .adc_i(adc_i),
    .adc_valid_i(adc_valid_i), .temp_i(temp_i), .cmd_valid_i(cmd_valid),
    .cmd_write_i(cmd_write), .cmd_addr_i(cmd_addr), .cmd_wdata_i(cmd_wdata),
    .comm_active_i(comm_active), .reply_bit_i(reply_bit), .nvm_rdata_i(nvm[nvm_addr]),
    .nvm_addr_o(nvm_addr), .nvm_wdata_o(nvm_wdata), .nvm_we_o(nvm_we), .rdata_o(rdata),
    .rvalid_o(rvalid), .range_sel_o(range_sel), .cfg_ready_o(cfg_ready),
    .locked_o(locked), .out_o(out));

  supply_programmer u_prog (.clk_i(clk_i), .locked_i(locked), .rvalid_i(rvalid),
    .rdata_i(rdata), .cmd_valid_o(cmd_valid), .cmd_write_o(cmd_write),
    .cmd_addr_o(cmd_addr), .cmd_wdata_o(cmd_wdata), .comm_active_o(comm_active),
    .reply_bit_o(reply_bit));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask

  task automatic do_reset;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 20 && cfg_ready !== 1'b1; i++) begin
      @(negedge clk_i);
      if (cfg_ready !== 1'b1) chk(16'(out), 16'h0001);
    end
    if (cfg_ready !== 1'b1) begin
      error_cnt++;
      finish_test;
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    logic ok;
    logic [15:0] q;
    u_prog.xfer(1'b1, a, d, ok, q);
    chk(16'(ok), 16'h0001);
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] q);
    logic ok;
    u_prog.xfer(1'b0, a, 16'h0000, ok, q);
    chk(16'(ok), 16'h0001);
  endtask

  // long enough for the fastest filter to settle
  task automatic settle(input logic [13:0] v);
    @(posedge clk_i);
    // only the clamp probes leave the filter bound, away from the switch points
    adc_i <= v;
    repeat (80) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_regs;
    logic ok;
    logic [15:0] q;
    chk(16'(range_sel), 16'h0003);
    u_prog.xfer(1'b1, 4'h3, 16'hffff, ok, q);
    chk(q, 16'h0800);
    chk(nvm[3], 16'h3fff);
    rd(4'h3, q);
    chk(q, 16'h3fff);
    wr(4'h9, 16'h1234);
    rd(4'h9, q);
    chk(q, 16'hbeef);
    chk(nvm[9], 16'hbeef);
    wr(4'h5, 16'hffff);
    wr(4'h6, 16'hffff);
    chk(nvm[5], 16'h07ff);
    chk(nvm[6], 16'h0fff);
    $display("test regs done");
  endtask

  task automatic test_switch;
    logic [15:0] q;
    wr(4'h0, 16'h0025);
    chk(16'(range_sel), 16'h0005);
    wr(4'h3, 16'h0800);
    wr(4'h4, 16'h0000);
    wr(4'h5, 16'h0190);
    wr(4'h6, 16'h03e8);
    settle(14'd1200);
    chk(16'(out), 16'h0000);
    settle(14'd700);
    chk(16'(out), 16'h0000);
    settle(14'd200);
    chk(16'(out), 16'h0001);
    settle(14'd700);
    chk(16'(out), 16'h0001);
    settle(14'h3ed4);
    rd(4'h8, q);
    chk(16'(q[15]), 16'h0001);
    wr(4'h3, 16'h1fff);
    wr(4'h4, 16'h0738);
    wr(4'h6, 16'h06a4);
    settle(14'h1f40);
    chk(16'(out), 16'h0001);
    rd(4'h8, q);
    chk(q, 16'h05e7);
    wr(4'h4, 16'h0000);
    settle(14'h1f40);
    chk(16'(out), 16'h0000);
    wr(4'h0, 16'h0015);
    settle(14'h1f40);
    rd(4'h8, q);
    chk(q, 16'h14aa);
    $display("test switch done");
  endtask

  task automatic test_temp;
    wr(4'h0, 16'h0025);
    wr(4'h3, 16'h0800);
    wr(4'h6, 16'h03e8);
    wr(4'h1, 16'h0040);
    settle(14'd200);
    chk(16'(out), 16'h0001);
    settle(14'd960);
    chk(16'(out), 16'h0001);
    @(posedge clk_i);
    temp_i <= 8'h10;
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    chk(16'(out), 16'h0000);
    settle(14'd200);
    chk(16'(out), 16'h0001);
    wr(4'h1, 16'h0000);
    wr(4'h2, 16'h0040);
    settle(14'd960);
    chk(16'(out), 16'h0000);
    @(posedge clk_i);
    temp_i <= 8'h00;
    $display("test temp done");
  endtask

  task automatic test_comm;
    u_prog.talk(1'b1);
    chk(16'(out), 16'h0001);
    u_prog.talk(1'b0);
    chk(16'(out), 16'h0000);
    u_prog.quiet();
    $display("test comm done");
  endtask

  task automatic test_lock;
    logic ok;
    logic [15:0] q;
    wr(4'h7, 16'h0001);
    chk(nvm[7], 16'h0001);
    chk(16'(locked), 16'h0000);
    do_reset;
    chk(16'(locked), 16'h0001);
    u_prog.xfer(1'b1, 4'h3, 16'h0000, ok, q);
    chk(16'(ok), 16'h0000);
    chk(nvm[3], 16'h0800);
    u_prog.xfer(1'b0, 4'h3, 16'h0000, ok, q);
    chk(16'(ok), 16'h0000);
    do_reset;
    chk(16'(locked), 16'h0001);
    $display("test lock done");
  endtask

  initial begin
    repeat (50000) @(posedge clk_i);
    error_cnt++;
    finish_test;
  end

  initial begin
    do_reset;
    test_regs;
    test_switch;
    test_comm;
    test_temp;
    test_lock;
    finish_test;
  end
endmodule
